// [verilog/bus_ctrl_defs.vh]
// Shared constants for the bus control and handover block
`ifndef BUS_CTRL_DEFS_VH
`define BUS_CTRL_DEFS_VH

// Cycle-type codes on the three status lines
`define CYC_ACK 3'h0
`define CYC_IO_RD 3'h1
`define CYC_IO_WR 3'h2
`define CYC_HALT 3'h3
`define CYC_FETCH 3'h4
`define CYC_MEM_RD 3'h5
`define CYC_MEM_WR 3'h6
`define CYC_PASSIVE 3'h7

// Status bit positions reused by the single-master pins
`define CODE_MEM_BIT 2
`define CODE_DIR_BIT 1

// Queue tracking codes
`define QS_NOP 2'h0
`define QS_FIRST 2'h1
`define QS_FLUSH 2'h2
`define QS_NEXT 2'h3

// Prefetch queue sizing
`define Q_DEPTH 6
`define Q_LAST 3'h5
`define Q_ROOM 3'h4
`define Q_ZERO 3'h0
`define Q_ONE 3'h1
`define Q_WORD 3'h2

// Strap level that selects single-master pins
`define STRAP_SINGLE 1'b1

`endif

// [verilog/prefetch_store.v]
// Six-byte storage for the prefetch queue, registered read port
`timescale 1ns/1ns
`include "bus_ctrl_defs.vh"
module prefetch_store (
	// Clock
	input wire core_clk,
	// Word write, low byte at wr_addr, high byte at wr_addr_b
	input wire wr_en,
	input wire [2:0] wr_addr,
	input wire [2:0] wr_addr_b,
	input wire [15:0] wr_data,
	// Read of the address that will be the head next cycle
	input wire [2:0] rd_addr,
	output reg [7:0] rd_data_ff
);

	reg [7:0] mem_ff [0:`Q_DEPTH-1];

	genvar i;
	generate
		for (i = 0; i < `Q_DEPTH; i = i + 1) begin : g_byte
			localparam [2:0] IDX = i;
			always @(posedge core_clk) begin
				if (wr_en && (wr_addr == IDX))
					mem_ff[i] <= wr_data[7:0];
				else if (wr_en && (wr_addr_b == IDX))
					mem_ff[i] <= wr_data[15:8];
			end
		end
	endgenerate

	// Forwarding makes a byte written into an empty queue usable at once
	always @(posedge core_clk) begin
		if (wr_en && (wr_addr == rd_addr))
			rd_data_ff <= wr_data[7:0];
		else if (wr_en && (wr_addr_b == rd_addr))
			rd_data_ff <= wr_data[15:8];
		else if (rd_addr <= `Q_LAST)
			rd_data_ff <= mem_ff[rd_addr];
		else
			rd_data_ff <= 8'h00;
	end

endmodule // prefetch_store

// [verilog/bus_handover_ctrl.v]
// Local bus sequencer, bus handover, lock, queue and control strobes
// Notes on behaviour
// - Yield the bus after the current cycle; channel 0 beats channel 1.
// - Grant is a one-clock low pulse in state four or one, float starts with it.
// - Third low pulse ends the tenure; drive again the following clock.
// - Three pulses per exchange, one dead clock between exchanges.
// - Release in state four only if early, not odd-first, ack, or locked.
// - Idle bus: release next clock, or start a cycle and apply rule five.
// - Lock output low from lock prefix until next instruction ends.
// - Queue status shows last clock's queue operation, four codes.
// - Memory/IO select: high memory, held through cycle, floats in hold.
// - Write strobe low in states two, three and waits of writes.
// - Acknowledge strobe low in states two, three and waits of acks.
// - Address latch pulse high in state one, never floated.
// - Direction output equals status bit one, floats in hold.
// - Transceiver enable low for transfers; writes start one state early.
// - Level hold is acknowledged in state four or one, bus floats.
// - Hold low drops acknowledge; bus driven again at the next cycle.
// - Level hold uses the same release terms; requester synchronises it.
// - Up to six prefetched bytes held first-in first-out.
// - Fetch a word whenever two or more bytes are free.
// - First byte into an empty queue is offered at once.
// - Status codes valid in states one and two, passive from three.
// - Cycle is four states at least; waits go between three and four.
// - Strap selects single-master or multi-master pin functions.
`timescale 1ns/1ns
`include "bus_ctrl_defs.vh"
module bus_handover_ctrl (
	// Clock and reset
	input wire core_clk,
	input wire rst_b,
	// Mode strap
	input wire config_strap,
	// Operand cycles from the execute unit
	input wire eu_req,
	input wire [2:0] eu_cyc_type,
	input wire eu_odd_first,
	input wire eu_irq_ack_strobe_n_first,
	output wire eu_ack,
	output wire eu_done,
	output wire [15:0] eu_rdata,
	// Instruction boundaries
	input wire lock_prefix,
	input wire instr_done,
	// Queue toward the execute unit
	input wire flush,
	input wire eu_take,
	input wire eu_take_first,
	output wire q_valid,
	output wire [7:0] q_byte,
	// Local bus data and timing
	input wire [15:0] bus_rdata,
	input wire ready,
	output wire bus_float,
	// Multi-master pins
	input wire master_handover_line_0_in,
	output wire master_handover_line_0_out,
	output wire master_handover_line_0_oe,
	input wire master_handover_line_1_in,
	output wire master_handover_line_1_out,
	output wire master_handover_line_1_oe,
	output wire cycle_code_2,
	output wire cycle_code_1,
	output wire cycle_code_0,
	output wire cycle_code_oe,
	output wire bus_lock_n,
	output wire bus_lock_oe,
	output wire prefetch_track_hi,
	output wire prefetch_track_lo,
	// Single-master pins
	input wire hold,
	output wire takeover_grant,
	output wire mem_io_sel,
	output wire mem_io_oe,
	output wire write_n,
	output wire write_oe,
	output wire irq_ack_strobe_n,
	output wire irq_ack_oe,
	output wire addr_latch,
	output wire xcvr_direction,
	output wire xcvr_direction_oe,
	output wire xcvr_enable_n,
	output wire xcvr_enable_oe
);

	localparam [5:0] B_IDLE = 6'h01;
	localparam [5:0] B_S1 = 6'h02;
	localparam [5:0] B_S2 = 6'h04;
	localparam [5:0] B_S3 = 6'h08;
	localparam [5:0] B_SW = 6'h10;
	localparam [5:0] B_S4 = 6'h20;

	localparam [4:0] H_OWN = 5'h01;
	localparam [4:0] H_PEND = 5'h02;
	localparam [4:0] H_GRANT = 5'h04;
	localparam [4:0] H_HELD = 5'h08;
	localparam [4:0] H_DEAD = 5'h10;

	function [2:0] inc_wrap;
		input [2:0] p;
		begin
			inc_wrap = (p == `Q_LAST) ? `Q_ZERO : p + `Q_ONE;
		end
	endfunction

	function is_write;
		input [2:0] code;
		begin
			is_write = (code == `CYC_IO_WR) || (code == `CYC_MEM_WR);
		end
	endfunction

	reg multi_ff;
	reg [5:0] b_ff;
	reg [5:0] nxt_b;
	reg [4:0] h_ff;
	reg [4:0] nxt_h;
	reg chan_ff;
	reg early_ff;
	reg [2:0] cyc_ff;
	reg odd_ff;
	reg irq_ack_strobe_n_ff;
	reg is_eu_ff;
	reg drop_ff;
	reg lock_ff;
	reg float_ff;
	reg grant_ff;
	reg [1:0] line_oe_ff;
	reg [2:0] code_ff;
	reg mem_io_ff;
	reg dir_ff;
	reg write_n_ff;
	reg ack_n_ff;
	reg ale_ff;
	reg xen_n_ff;
	reg [1:0] qs_ff;
	reg eu_done_ff;
	reg [15:0] eu_rdata_ff;
	reg [2:0] cnt_ff;
	reg [2:0] wr_ptr_ff;
	reg [2:0] rd_ptr_ff;

	// Strap is static; sampled on every clock while reset is held
	always @(posedge core_clk) begin
		if (!rst_b)
			multi_ff <= (config_strap != `STRAP_SINGLE);
	end

	// Requests: pulses only in multi mode, level only in single mode
	wire [1:0] line_in = {master_handover_line_1_in,
		master_handover_line_0_in};
	wire [1:0] pulse_req = multi_ff ? ~line_in : 2'b00;
	wire hold_req = !multi_ff && hold;
	wire any_req = (|pulse_req) || hold_req;

	wire b_idle = (b_ff == B_IDLE);
	wire b_s4 = (b_ff == B_S4);
	wire h_pend = (h_ff == H_PEND);
	wire cond_ok = !odd_ff && !irq_ack_strobe_n_ff && !lock_ff;
	wire rel_now = h_pend && ((b_s4 && early_ff && cond_ok) ||
		(b_idle && !lock_ff));

	// Queue decisions
	wire want_fetch = (cnt_ff <= `Q_ROOM) && !flush;
	wire start_req = eu_req || want_fetch;
	wire may_start = (h_ff == H_OWN) || (h_ff == H_DEAD) || h_pend;
	wire start_ok = may_start && !rel_now && start_req;
	wire done_now = ((b_ff == B_S3) || (b_ff == B_SW)) && ready;
	wire wr_q = done_now && !is_eu_ff && !drop_ff && !flush;
	wire rd_q = eu_take && (cnt_ff != `Q_ZERO) && !flush;
	wire [2:0] new_type = eu_req ? eu_cyc_type : `CYC_FETCH;

	// Bus cycle sequencer
	always @* begin
		nxt_b = b_ff;
		case (b_ff)
		B_IDLE: begin
			if (start_ok)
				nxt_b = B_S1;
		end
		B_S1: nxt_b = B_S2;
		B_S2: nxt_b = B_S3;
		B_S3: nxt_b = ready ? B_S4 : B_SW;
		B_SW: nxt_b = ready ? B_S4 : B_SW;
		B_S4: nxt_b = start_ok ? B_S1 : B_IDLE;
		default: nxt_b = B_IDLE;
		endcase
	end

	wire starting = (nxt_b == B_S1);
	wire [2:0] nxt_cyc = starting ? new_type : cyc_ff;
	assign eu_ack = starting && eu_req;

	// Ownership exchange
	always @* begin
		nxt_h = h_ff;
		case (h_ff)
		H_OWN: begin
			if (any_req)
				nxt_h = H_PEND;
		end
		H_PEND: begin
			if (!multi_ff && !hold)
				nxt_h = H_OWN;
			else if (rel_now)
				nxt_h = multi_ff ? H_GRANT : H_HELD;
		end
		H_GRANT: nxt_h = H_HELD;
		H_HELD: begin
			if (multi_ff ? !line_in[chan_ff] : !hold)
				nxt_h = H_DEAD;
		end
		H_DEAD: nxt_h = H_OWN;
		default: nxt_h = H_OWN;
		endcase
	end

	always @(posedge core_clk) begin
		if (!rst_b) begin
			b_ff <= B_IDLE;
			h_ff <= H_OWN;
			chan_ff <= 1'b0;
			early_ff <= 1'b0;
			line_oe_ff <= 2'b00;
			grant_ff <= 1'b0;
			float_ff <= 1'b0;
		end else begin
			b_ff <= nxt_b;
			h_ff <= nxt_h;
			if ((h_ff == H_OWN) && any_req) begin
				chan_ff <= !pulse_req[0];
				early_ff <= (b_ff == B_IDLE) || (b_ff == B_S1) ||
					(b_ff == B_S2);
			end else if (h_pend && starting) begin
				early_ff <= 1'b1;
			end
			// Grant pulse on the requesting channel only
			line_oe_ff[0] <= (nxt_h == H_GRANT) && !chan_ff;
			line_oe_ff[1] <= (nxt_h == H_GRANT) && chan_ff;
			grant_ff <= (nxt_h == H_HELD) && !multi_ff;
			// Single mode keeps floating until it needs the bus again
			float_ff <= (nxt_h == H_GRANT) || (nxt_h == H_HELD) ||
				(float_ff && !multi_ff && !starting);
		end
	end

	// Cycle attributes latched as the cycle starts
	always @(posedge core_clk) begin
		if (!rst_b) begin
			cyc_ff <= `CYC_PASSIVE;
			odd_ff <= 1'b0;
			irq_ack_strobe_n_ff <= 1'b0;
			is_eu_ff <= 1'b0;
			drop_ff <= 1'b0;
		end else begin
			if (starting) begin
				cyc_ff <= new_type;
				odd_ff <= eu_req && eu_odd_first;
				irq_ack_strobe_n_ff <= eu_req && eu_irq_ack_strobe_n_first;
				is_eu_ff <= eu_req;
			end
			// A fetch in flight across a flush brings stale code
			if (starting)
				drop_ff <= 1'b0;
			else if (flush && !b_idle)
				drop_ff <= 1'b1;
		end
	end

	// Lock: set wins over an end of instruction in the same clock
	always @(posedge core_clk) begin
		if (!rst_b)
			lock_ff <= 1'b0;
		else if (lock_prefix)
			lock_ff <= 1'b1;
		else if (instr_done)
			lock_ff <= 1'b0;
	end

	// Control strobes, timed from the state about to be entered
	wire n_s1 = (nxt_b == B_S1);
	wire n_s2 = (nxt_b == B_S2);
	wire n_mid = (nxt_b == B_S3) || (nxt_b == B_SW);
	wire n_s4 = (nxt_b == B_S4);
	wire n_busy = !(nxt_b == B_IDLE);
	wire n_xfer = n_busy && (nxt_cyc != `CYC_HALT);

	always @(posedge core_clk) begin
		if (!rst_b) begin
			code_ff <= `CYC_PASSIVE;
			mem_io_ff <= 1'b0;
			dir_ff <= 1'b0;
			write_n_ff <= 1'b1;
			ack_n_ff <= 1'b1;
			ale_ff <= 1'b0;
			xen_n_ff <= 1'b1;
		end else begin
			code_ff <= (n_s1 || n_s2) ? nxt_cyc : `CYC_PASSIVE;
			if (n_busy) begin
				mem_io_ff <= nxt_cyc[`CODE_MEM_BIT];
				dir_ff <= nxt_cyc[`CODE_DIR_BIT];
			end
			write_n_ff <= !((n_s2 || n_mid) && is_write(nxt_cyc));
			ack_n_ff <= !((n_s2 || n_mid) &&
				(nxt_cyc == `CYC_ACK));
			ale_ff <= n_s1;
			// Clock resolution: a read opens a state later than a write
			xen_n_ff <= !(n_xfer && (n_mid || n_s4 ||
				(n_s2 && is_write(nxt_cyc))));
		end
	end

	// Prefetch queue bookkeeping
	wire [2:0] wr_ptr_b = inc_wrap(wr_ptr_ff);
	wire [2:0] nxt_rd_ptr = flush ? `Q_ZERO :
		(rd_q ? inc_wrap(rd_ptr_ff) : rd_ptr_ff);

	always @(posedge core_clk) begin
		if (!rst_b) begin
			cnt_ff <= `Q_ZERO;
			wr_ptr_ff <= `Q_ZERO;
			rd_ptr_ff <= `Q_ZERO;
			qs_ff <= `QS_NOP;
			eu_done_ff <= 1'b0;
			eu_rdata_ff <= 16'h0000;
		end else begin
			rd_ptr_ff <= nxt_rd_ptr;
			if (flush) begin
				cnt_ff <= `Q_ZERO;
				wr_ptr_ff <= `Q_ZERO;
			end else begin
				cnt_ff <= cnt_ff + (wr_q ? `Q_WORD : `Q_ZERO) -
					(rd_q ? `Q_ONE : `Q_ZERO);
				if (wr_q)
					wr_ptr_ff <= inc_wrap(wr_ptr_b);
			end
			if (flush)
				qs_ff <= `QS_FLUSH;
			else if (rd_q)
				qs_ff <= eu_take_first ? `QS_FIRST : `QS_NEXT;
			else
				qs_ff <= `QS_NOP;
			eu_done_ff <= done_now && is_eu_ff;
			if (done_now && is_eu_ff)
				eu_rdata_ff <= bus_rdata;
		end
	end

	prefetch_store u_store (
		.core_clk(core_clk),
		.wr_en(wr_q),
		.wr_addr(wr_ptr_ff),
		.wr_addr_b(wr_ptr_b),
		.wr_data(bus_rdata),
		.rd_addr(nxt_rd_ptr),
		.rd_data_ff(q_byte)
	);

	// Outputs
	assign q_valid = (cnt_ff != `Q_ZERO);
	assign eu_done = eu_done_ff;
	assign eu_rdata = eu_rdata_ff;
	assign bus_float = float_ff;
	assign master_handover_line_0_out = 1'b0;
	assign master_handover_line_0_oe = line_oe_ff[0];
	assign master_handover_line_1_out = 1'b0;
	assign master_handover_line_1_oe = line_oe_ff[1];
	assign cycle_code_2 = code_ff[2];
	assign cycle_code_1 = code_ff[1];
	assign cycle_code_0 = code_ff[0];
	assign cycle_code_oe = multi_ff && !float_ff;
	assign bus_lock_n = !lock_ff;
	assign bus_lock_oe = multi_ff && !float_ff;
	assign prefetch_track_hi = qs_ff[1];
	assign prefetch_track_lo = qs_ff[0];
	assign takeover_grant = grant_ff;
	assign mem_io_sel = mem_io_ff;
	assign mem_io_oe = !multi_ff && !float_ff;
	assign write_n = write_n_ff;
	assign write_oe = !multi_ff && !float_ff;
	assign irq_ack_strobe_n = ack_n_ff;
	assign irq_ack_oe = !multi_ff && !float_ff;
	assign addr_latch = ale_ff;
	assign xcvr_direction = dir_ff;
	assign xcvr_direction_oe = !multi_ff && !float_ff;
	assign xcvr_enable_n = xen_n_ff;
	assign xcvr_enable_oe = !multi_ff && !float_ff;

endmodule // bus_handover_ctrl

// [dv/bus_handover_props.sv]
// Assertion checker for the bus handover and control block
`timescale 1ns/1ns
module bus_handover_props (
	// Clock and reset
	input wire core_clk,
	input wire rst_b,
	// Inputs watched
	input wire flush,
	input wire lock_prefix,
	input wire hold,
	// Outputs watched
	input wire takeover_grant,
	input wire bus_float,
	input wire addr_latch,
	input wire cycle_code_2,
	input wire cycle_code_1,
	input wire cycle_code_0,
	input wire write_n,
	input wire write_oe,
	input wire mem_io_oe,
	input wire irq_ack_strobe_n,
	input wire xcvr_direction,
	input wire bus_lock_n,
	input wire prefetch_track_hi,
	input wire prefetch_track_lo,
	input wire master_handover_line_0_oe,
	input wire master_handover_line_1_oe
);
	wire [2:0] code = {cycle_code_2, cycle_code_1, cycle_code_0};
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	AST_ALE_CODE: assert property (addr_latch |-> code != 3'h7)
		else $error("passive code during address latch");
	AST_ALE_GAP: assert property (addr_latch |=> !addr_latch [*3])
		else $error("bus cycle shorter than four states");
	AST_WR_START: assert property ($fell(write_n) |-> $past(addr_latch))
		else $error("write strobe not started after state one");
	AST_WR_DIR: assert property (!write_n |-> xcvr_direction)
		else $error("direction not transmit during write");
	AST_ACK_DIR: assert property (!irq_ack_strobe_n |-> !xcvr_direction)
		else $error("direction not receive during acknowledge");
	AST_GRANT: assert property (master_handover_line_0_oe |->
		bus_float ##1 !master_handover_line_0_oe)
		else $error("grant pulse wrong width or bus not floated");
	AST_ONE_OWNER: assert property (!(master_handover_line_0_oe &&
		master_handover_line_1_oe))
		else $error("both channels granted");
	AST_FLOAT_OFF: assert property (bus_float |-> !write_oe && !mem_io_oe)
		else $error("control lines driven while floated");
	AST_QS_FLUSH: assert property (flush |=>
		{prefetch_track_hi, prefetch_track_lo} == 2'h2)
		else $error("flush not reported on queue status");
	AST_LOCK_SET: assert property (lock_prefix |=> !bus_lock_n)
		else $error("lock output not asserted");
	AST_HOLD_DROP: assert property (!hold && takeover_grant |=>
		!takeover_grant)
		else $error("hold acknowledge not dropped");
	cover property ($rose(takeover_grant));
	cover property (master_handover_line_0_oe);
	cover property (!write_n ##1 !write_n ##1 !write_n);
endmodule // bus_handover_props

bind bus_handover_ctrl bus_handover_props props_i (
	.core_clk(core_clk), .rst_b(rst_b), .flush(flush),
	.lock_prefix(lock_prefix), .hold(hold),
	.takeover_grant(takeover_grant), .bus_float(bus_float),
	.addr_latch(addr_latch), .cycle_code_2(cycle_code_2),
	.cycle_code_1(cycle_code_1), .cycle_code_0(cycle_code_0),
	.write_n(write_n), .write_oe(write_oe), .mem_io_oe(mem_io_oe),
	.irq_ack_strobe_n(irq_ack_strobe_n),
	.xcvr_direction(xcvr_direction), .bus_lock_n(bus_lock_n),
	.prefetch_track_hi(prefetch_track_hi),
	.prefetch_track_lo(prefetch_track_lo),
	.master_handover_line_0_oe(master_handover_line_0_oe),
	.master_handover_line_1_oe(master_handover_line_1_oe)
);

// [dv/far_side_models.sv]
// Far-side models: requesting bus master and slow memory
`timescale 1ns/1ns
module handover_master_model #(
	parameter [3:0] TENURE = 4'h4
) (
	// Clock and command
	input wire core_clk,
	input wire go,
	// Open-drain request/grant line
	input wire grant_oe,
	output wire line_in
);
	reg drive_ff = 1'b0;
	reg [1:0] phase_ff = 2'h0;
	reg [3:0] cnt_ff = 4'h0;
	// Pull-up unless either side sinks the line
	assign line_in = !(drive_ff | grant_oe);
	always @(posedge core_clk) begin
		drive_ff <= 1'b0;
		case (phase_ff)
		2'h0: if (go) begin
			drive_ff <= 1'b1;
			phase_ff <= 2'h1;
		end
		2'h1: if (grant_oe) begin
			cnt_ff <= TENURE;
			phase_ff <= 2'h2;
		end
		default: if (cnt_ff == 4'h0) begin
			drive_ff <= 1'b1;
			phase_ff <= 2'h0;
		end else begin
			cnt_ff <= cnt_ff - 4'h1;
		end
		endcase
	end
endmodule // handover_master_model

module slow_memory_model #(
	parameter [15:0] WORD = 16'h5aa5
) (
	input wire core_clk,
	input wire addr_latch,
	input wire [1:0] n_wait,
	output wire ready,
	output wire [15:0] bus_rdata
);
	reg [2:0] cnt_ff = 3'h0;
	assign ready = cnt_ff < 3'h2;
	// Data valid only at the sampling clock, garbage otherwise
	assign bus_rdata = (cnt_ff == 3'h1) ? WORD : ~WORD;
	always @(posedge core_clk) begin
		if (addr_latch)
			cnt_ff <= {1'b0, n_wait} + 3'h2;
		else if (cnt_ff != 3'h0)
			cnt_ff <= cnt_ff - 3'h1;
	end
endmodule // slow_memory_model

// [dv/bus_handover_ctrl_tb.sv]
// Self-checking bench for the bus handover and control block
`timescale 1ns/1ns
module bus_handover_ctrl_tb;
	reg core_clk = 1'b0;
	reg rst_b = 1'b0;
	reg config_strap = 1'b1;
	reg eu_req = 1'b0;
	reg [2:0] eu_cyc_type = 3'h0;
	reg lock_prefix = 1'b0;
	reg instr_done = 1'b0;
	reg flush = 1'b0;
	reg eu_take = 1'b0;
	reg eu_take_first = 1'b0;
	reg hold = 1'b0;
	reg go0 = 1'b0;
	reg go1 = 1'b0;
	reg [1:0] n_wait = 2'h0;
	integer bad_count = 0;
	integer n_tests = 0;
	integer i, k, cnt_a, cnt_b;
	reg [14:0] tbl;
	reg [2:0] ty;
	wire eu_ack, q_valid, ready, bus_float, rq0_in, rq1_in, rq0_oe, rq1_oe;
	wire cycle_code_2, cycle_code_1, cycle_code_0, bus_lock_n, write_oe;
	wire prefetch_track_hi, prefetch_track_lo, takeover_grant, mem_io_sel;
	wire write_n, irq_ack_strobe_n, addr_latch, xcvr_direction;
	wire xcvr_enable_n;
	wire [15:0] eu_rdata, bus_rdata;
	wire [7:0] q_byte;
	always #2 core_clk = ~core_clk;
	bus_handover_ctrl dut (
		.core_clk(core_clk), .rst_b(rst_b), .config_strap(config_strap),
		.eu_req(eu_req), .eu_cyc_type(eu_cyc_type), .eu_odd_first(1'b0),
		.eu_irq_ack_strobe_n_first(1'b0), .eu_ack(eu_ack), .eu_done(),
		.eu_rdata(eu_rdata), .lock_prefix(lock_prefix),
		.instr_done(instr_done), .flush(flush), .eu_take(eu_take),
		.eu_take_first(eu_take_first), .q_valid(q_valid), .q_byte(q_byte),
		.bus_rdata(bus_rdata), .ready(ready), .bus_float(bus_float),
		.master_handover_line_0_in(rq0_in), .master_handover_line_0_out(),
		.master_handover_line_0_oe(rq0_oe),
		.master_handover_line_1_in(rq1_in), .master_handover_line_1_out(),
		.master_handover_line_1_oe(rq1_oe), .cycle_code_2(cycle_code_2),
		.cycle_code_1(cycle_code_1), .cycle_code_0(cycle_code_0),
		.cycle_code_oe(), .bus_lock_n(bus_lock_n), .bus_lock_oe(),
		.prefetch_track_hi(prefetch_track_hi),
		.prefetch_track_lo(prefetch_track_lo), .hold(hold),
		.takeover_grant(takeover_grant), .mem_io_sel(mem_io_sel),
		.mem_io_oe(), .write_n(write_n), .write_oe(write_oe),
		.irq_ack_strobe_n(irq_ack_strobe_n), .irq_ack_oe(),
		.addr_latch(addr_latch), .xcvr_direction(xcvr_direction),
		.xcvr_direction_oe(), .xcvr_enable_n(xcvr_enable_n),
		.xcvr_enable_oe()
	);
	handover_master_model m0 (.core_clk(core_clk), .go(go0),
		.grant_oe(rq0_oe), .line_in(rq0_in));
	handover_master_model m1 (.core_clk(core_clk), .go(go1),
		.grant_oe(rq1_oe), .line_in(rq1_in));
	slow_memory_model mem (.core_clk(core_clk), .addr_latch(addr_latch),
		.n_wait(n_wait), .ready(ready), .bus_rdata(bus_rdata));
	task check(input [31:0] seen, input [31:0] exp, input [8*8-1:0] what);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("mismatch %0s exp %h seen %h", what, exp, seen);
			end
		end
	endtask
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", n_tests, bad_count);
			if (bad_count == 0 && n_tests > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task do_reset(input strap);
		begin
			rst_b = 1'b0;
			config_strap = strap;
			repeat (12) @(negedge core_clk);
			check(write_n, 1, "wr_rst");
			check(addr_latch, 0, "ale_rst");
			check({prefetch_track_hi, prefetch_track_lo}, 0, "qs_rst");
			check(write_oe, strap, "mode");
			rst_b = 1'b1;
			$display("reset done");
		end
	endtask
	task t_cycles;
		begin
			for (i = 0; i < 5; i = i + 1) begin
				tbl = 15'h6a88 >> (3 * i);
				ty = tbl[2:0];
				n_wait = i % 3;
				eu_cyc_type = ty;
				eu_req = 1'b1;
				// Let the combinational acknowledge settle first
				#1;
				for (k = 0; k < 40 && eu_ack !== 1'b1; k = k + 1)
					@(negedge core_clk);
				@(negedge core_clk);
				eu_req = 1'b0;
				check(addr_latch, 1, "ale");
				check({cycle_code_2, cycle_code_1, cycle_code_0}, ty, "code");
				check(mem_io_sel, ty[2], "memio");
				check(xcvr_direction, ty[1], "dir");
				check(xcvr_enable_n, 1, "xen_s1");
				@(negedge core_clk);
				check(xcvr_enable_n, !ty[1], "xen_s2");
				cnt_a = (write_n === 1'b0);
				cnt_b = (irq_ack_strobe_n === 1'b0);
				repeat (11) begin
					@(negedge core_clk);
					cnt_a = cnt_a + (write_n === 1'b0);
					cnt_b = cnt_b + (irq_ack_strobe_n === 1'b0);
				end
				check(cnt_a, ty[1] ? 2 + n_wait : 0, "wr_len");
				check(cnt_b, ty == 3'h0 ? 2 + n_wait : 0, "ack_len");
				if (ty[0])
					check(eu_rdata, 16'h5aa5, "rdata");
			end
			n_wait = 2'h0;
			$display("bus cycles done");
		end
	endtask
	task t_queue;
		begin
			flush = 1'b1;
			@(negedge core_clk);
			flush = 1'b0;
			check({prefetch_track_hi, prefetch_track_lo}, 2, "qs_fl");
			@(negedge core_clk);
			for (k = 0; k < 40 && q_valid !== 1'b1; k = k + 1)
				@(negedge core_clk);
			repeat (20) @(negedge core_clk);
			check(q_byte, 8'ha5, "head");
			eu_take = 1'b1;
			eu_take_first = 1'b1;
			@(negedge core_clk);
			eu_take_first = 1'b0;
			check({prefetch_track_hi, prefetch_track_lo}, 1, "qs_1st");
			check(q_byte, 8'h5a, "order");
			@(negedge core_clk);
			eu_take = 1'b0;
			check({prefetch_track_hi, prefetch_track_lo}, 3, "qs_nxt");
			$display("queue done");
		end
	endtask
	task t_hold;
		begin
			hold = 1'b1;
			for (k = 0; k < 40 && takeover_grant !== 1'b1; k = k + 1)
				@(negedge core_clk);
			check(takeover_grant, 1, "takeover_grant");
			check(write_oe, 0, "hld_fl");
			hold = 1'b0;
			@(negedge core_clk);
			check(takeover_grant, 0, "takeover_grant_dn");
			$display("hold done");
		end
	endtask
	task t_grant;
		begin
			lock_prefix = 1'b1;
			@(negedge core_clk);
			lock_prefix = 1'b0;
			go0 = 1'b1;
			@(negedge core_clk);
			go0 = 1'b0;
			cnt_a = 0;
			repeat (16) begin
				@(negedge core_clk);
				cnt_a = cnt_a + (rq0_oe === 1'b1);
			end
			check(cnt_a, 0, "lockgnt");
			instr_done = 1'b1;
			@(negedge core_clk);
			instr_done = 1'b0;
			for (k = 0; k < 40 && rq0_oe !== 1'b1; k = k + 1)
				@(negedge core_clk);
			check(rq0_oe, 1, "grant0");
			check(bus_float, 1, "float");
			for (k = 0; k < 20 && bus_float !== 1'b0; k = k + 1)
				@(negedge core_clk);
			check(bus_float, 0, "reclaim");
			repeat (4) @(negedge core_clk);
			go0 = 1'b1;
			go1 = 1'b1;
			@(negedge core_clk);
			go0 = 1'b0;
			go1 = 1'b0;
			cnt_b = 0;
			for (k = 0; k < 40 && rq0_oe !== 1'b1; k = k + 1) begin
				@(negedge core_clk);
				cnt_b = cnt_b + (rq1_oe === 1'b1);
			end
			check(rq0_oe, 1, "prio0");
			check(cnt_b, 0, "prio1");
			$display("handover done");
		end
	endtask
	// Whole run is a few hundred clocks; this leaves ample margin
	initial begin
		#40000;
		bad_count = bad_count + 1;
		end_of_test;
	end
	initial begin
		do_reset(1'b1);
		t_cycles;
		t_queue;
		t_hold;
		do_reset(1'b0);
		t_grant;
		end_of_test;
	end
endmodule // bus_handover_ctrl_tb
